/* common/ext_bus_pkg.sv */
// Shared constants and types for the external memory bus pin block
package ext_bus_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int SEG_W = 8;
  localparam int SEG_LSB = 16;
  localparam int WAIT_W = 4;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [15:0] WORD_ONES = 16'hffff;
  localparam logic [1:0] SEG_NONE = 2'h0;
  localparam logic [1:0] SEG_TWO = 2'h1;
  localparam logic [1:0] SEG_FOUR = 2'h2;
  localparam logic [1:0] SEG_EIGHT = 2'h3;
  localparam logic [7:0] SEG_MASK_TWO = 8'h03;
  localparam logic [7:0] SEG_MASK_FOUR = 8'h0f;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_STROBE = 2'b10,
    ST_HOLD = 2'b11
  } bus_state_e;
endpackage

/* hdl/external_memory_bus_pins.sv */
// External memory bus pin sequencer: strobes, address latch, port muxing, strap
// Overview of operation
// - Each segment port bit is separately an input or an output, and an input bit has its driver off.
// - With the external bus on, the segment select picks the segment port bits that carry address lines from A16: none, bits 0-1, 0-3 or 0-7 (A16 to A23).
// - The read strobe is asserted on every external instruction fetch or data read.
// - In plain write mode the write strobe is asserted on every external data write.
// - In low-byte mode the write strobe fires only for low-byte writes on a 16-bit bus, but on every write on an 8-bit bus.
// - With ready enabled, a high ready input during an access keeps adding wait states until it goes low.
// - An address latch strobe is driven so that outside latches can capture the multiplexed address.
// - The fetch strap is sampled around reset; low selects external code fetch, high internal memory.
// - In demultiplexed mode the shared port carries D0-D7 low, D8-D15 high at 16 bits, else general I/O high.
// - In demultiplexed mode the low address port drives the 16-bit low address.
`timescale 1ns/1ps
`default_nettype none
module external_memory_bus_pins (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ext_bus_en,
  input wire logic i_bus_mux,
  input wire logic i_bus_16bit,
  input wire logic i_write_strobe_mode_select,
  input wire logic i_ready_en,
  input wire logic [ext_bus_pkg::WAIT_W-1:0] i_wait_states,
  input wire logic [1:0] i_seg_sel,
  input wire logic i_acc_req,
  input wire logic i_acc_write,
  input wire logic i_acc_low_byte,
  input wire logic [ext_bus_pkg::ADDR_W-1:0] i_acc_addr,
  input wire logic [ext_bus_pkg::DATA_W-1:0] i_acc_wdata,
  output logic o_acc_done,
  output logic [ext_bus_pkg::DATA_W-1:0] o_acc_rdata,
  input wire logic [ext_bus_pkg::SEG_W-1:0] i_seg_gpio_dir,
  input wire logic [ext_bus_pkg::SEG_W-1:0] i_seg_gpio_out,
  input wire logic [ext_bus_pkg::DATA_W-1:0] i_shared_gpio_dir,
  input wire logic [ext_bus_pkg::DATA_W-1:0] i_shared_gpio_out,
  input wire logic [ext_bus_pkg::DATA_W-1:0] i_low_addr_gpio_dir,
  input wire logic [ext_bus_pkg::DATA_W-1:0] i_low_addr_gpio_out,
  input wire logic [ext_bus_pkg::SEG_W-1:0] i_segment_port_in,
  output logic [ext_bus_pkg::SEG_W-1:0] o_segment_port_out,
  output logic [ext_bus_pkg::SEG_W-1:0] o_segment_port_oe,
  output logic [ext_bus_pkg::SEG_W-1:0] o_segment_port_sync,
  input wire logic [ext_bus_pkg::DATA_W-1:0] i_shared_addr_data_port_in,
  output logic [ext_bus_pkg::DATA_W-1:0] o_shared_addr_data_port_out,
  output logic [ext_bus_pkg::DATA_W-1:0] o_shared_addr_data_port_oe,
  output logic [ext_bus_pkg::DATA_W-1:0] o_shared_port_sync,
  output logic [ext_bus_pkg::DATA_W-1:0] o_low_address_port_out,
  output logic [ext_bus_pkg::DATA_W-1:0] o_low_address_port_oe,
  output logic o_read_strobe_n,
  output logic o_low_byte_write_strobe_n,
  output logic o_addr_latch,
  input wire logic i_ready,
  input wire logic i_external_fetch_strap_n,
  output logic o_boot_external,
  output logic o_boot_valid
);
  import ext_bus_pkg::*;
  // Pin synchronisers; first stages feed only the second stages
  logic [SEG_W-1:0] seg_meta_reg, seg_sync_reg;
  logic [DATA_W-1:0] shr_meta_reg, shr_sync_reg;
  logic ready_meta_reg, ready_sync_reg, strap_meta_reg, strap_sync_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seg_meta_reg <= '0;
      seg_sync_reg <= '0;
      shr_meta_reg <= '0;
      shr_sync_reg <= '0;
      ready_meta_reg <= 1'b0;
      ready_sync_reg <= 1'b0;
      strap_meta_reg <= 1'b1;
      strap_sync_reg <= 1'b1;
    end else begin
      seg_meta_reg <= i_segment_port_in;
      seg_sync_reg <= seg_meta_reg;
      shr_meta_reg <= i_shared_addr_data_port_in;
      shr_sync_reg <= shr_meta_reg;
      ready_meta_reg <= i_ready;
      ready_sync_reg <= ready_meta_reg;
      strap_meta_reg <= i_external_fetch_strap_n;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // Strap capture after release, once the synchroniser holds a real sample
  logic [1:0] strap_cnt_reg, strap_cnt_next;
  logic boot_ext_reg, boot_ext_next, boot_valid_reg, boot_valid_next;

  always_comb begin
    strap_cnt_next = strap_cnt_reg;
    boot_ext_next = boot_ext_reg;
    boot_valid_next = boot_valid_reg;
    if (!boot_valid_reg) begin
      if (strap_cnt_reg == STRAP_SETTLE) begin
        boot_ext_next = !strap_sync_reg;
        boot_valid_next = 1'b1;
      end else begin
        strap_cnt_next = strap_cnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_cnt_reg <= '0;
      boot_ext_reg <= 1'b0;
      boot_valid_reg <= 1'b0;
    end else begin
      strap_cnt_reg <= strap_cnt_next;
      boot_ext_reg <= boot_ext_next;
      boot_valid_reg <= boot_valid_next;
    end
  end

  // Access sequencer; configuration frozen for the length of an access
  bus_state_e state_reg, state_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic [WAIT_W-1:0] wait_cnt_reg, wait_cnt_next;
  logic wr_reg, wr_next, low_reg, low_next, done_reg, done_next;
  logic mux_reg, mux_next, wide_reg, wide_next, lbmode_reg, lbmode_next;
  logic rdy_en_reg, rdy_en_next, bus_en_reg, bus_en_next, take;
  logic [1:0] seg_sel_reg, seg_sel_next;

  always_comb begin
    take = (state_reg == ST_IDLE) && i_acc_req && i_ext_bus_en;
    state_next = state_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    wait_cnt_next = wait_cnt_reg;
    wr_next = wr_reg;
    low_next = low_reg;
    done_next = 1'b0;
    mux_next = mux_reg;
    wide_next = wide_reg;
    lbmode_next = lbmode_reg;
    rdy_en_next = rdy_en_reg;
    bus_en_next = bus_en_reg;
    seg_sel_next = seg_sel_reg;
    unique case (state_reg)
      ST_IDLE: begin
        mux_next = i_bus_mux;
        wide_next = i_bus_16bit;
        lbmode_next = i_write_strobe_mode_select;
        rdy_en_next = i_ready_en;
        bus_en_next = i_ext_bus_en;
        seg_sel_next = i_seg_sel;
        if (take) begin
          addr_next = i_acc_addr;
          wdata_next = i_acc_wdata;
          wr_next = i_acc_write;
          low_next = i_acc_low_byte;
          state_next = ST_ADDR;
        end
      end
      ST_ADDR: begin
        wait_cnt_next = i_wait_states;
        state_next = ST_STROBE;
      end
      ST_STROBE: begin
        if (wait_cnt_reg != '0) begin
          wait_cnt_next = wait_cnt_reg - WAIT_W'(1);
        end else if (!(rdy_en_reg && ready_sync_reg)) begin
          rdata_next = wide_reg ? shr_sync_reg : {BYTE_ZERO, shr_sync_reg[7:0]};
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        done_next = 1'b1;
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_IDLE;
      addr_reg <= '0;
      wdata_reg <= '0;
      rdata_reg <= '0;
      wait_cnt_reg <= '0;
      wr_reg <= 1'b0;
      low_reg <= 1'b0;
      done_reg <= 1'b0;
      mux_reg <= 1'b0;
      wide_reg <= 1'b0;
      lbmode_reg <= 1'b0;
      rdy_en_reg <= 1'b0;
      bus_en_reg <= 1'b0;
      seg_sel_reg <= SEG_NONE;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      wait_cnt_reg <= wait_cnt_next;
      wr_reg <= wr_next;
      low_reg <= low_next;
      done_reg <= done_next;
      mux_reg <= mux_next;
      wide_reg <= wide_next;
      lbmode_reg <= lbmode_next;
      rdy_en_reg <= rdy_en_next;
      bus_en_reg <= bus_en_next;
      seg_sel_reg <= seg_sel_next;
    end
  end

  // Pin drive computed from next state so every pin is a flop output
  logic [SEG_W-1:0] seg_out_reg, seg_out_next, seg_oe_reg, seg_oe_next, seg_mask;
  logic [DATA_W-1:0] shr_out_reg, shr_out_next, shr_oe_reg, shr_oe_next;
  logic [DATA_W-1:0] la_out_reg, la_out_next, la_oe_reg, la_oe_next;
  logic rd_n_reg, rd_n_next, wr_n_reg, wr_n_next, ale_reg, ale_next, data_phase;

  always_comb begin
    data_phase = (state_next == ST_STROBE) || (state_next == ST_HOLD);
    unique case (bus_en_next ? seg_sel_next : SEG_NONE)
      SEG_NONE: seg_mask = BYTE_ZERO;
      SEG_TWO: seg_mask = SEG_MASK_TWO;
      SEG_FOUR: seg_mask = SEG_MASK_FOUR;
      SEG_EIGHT: seg_mask = BYTE_ONES;
    endcase
    seg_out_next = (seg_mask & addr_next[SEG_LSB +: SEG_W]) | (~seg_mask & i_seg_gpio_out);
    seg_oe_next = seg_mask | i_seg_gpio_dir;
    la_out_next = i_low_addr_gpio_out;
    la_oe_next = i_low_addr_gpio_dir;
    shr_out_next = i_shared_gpio_out;
    shr_oe_next = i_shared_gpio_dir;
    if (bus_en_next && !mux_next) begin
      la_out_next = addr_next[15:0];
      la_oe_next = WORD_ONES;
      shr_out_next[7:0] = wdata_next[7:0];
      shr_oe_next[7:0] = (data_phase && wr_next) ? BYTE_ONES : BYTE_ZERO;
      if (wide_next) begin
        shr_out_next[15:8] = wdata_next[15:8];
        shr_oe_next[15:8] = (data_phase && wr_next) ? BYTE_ONES : BYTE_ZERO;
      end
    end else if (bus_en_next) begin
      // Idle multiplexed bus floats AD so slow devices can release it
      shr_out_next[7:0] = (state_next == ST_ADDR) ? addr_next[7:0] : wdata_next[7:0];
      shr_oe_next[7:0] = ((state_next == ST_ADDR) || (data_phase && wr_next)) ? BYTE_ONES : BYTE_ZERO;
      if (wide_next) begin
        shr_out_next[15:8] = (state_next == ST_ADDR) ? addr_next[15:8] : wdata_next[15:8];
        shr_oe_next[15:8] = shr_oe_next[7:0];
      end else begin
        shr_out_next[15:8] = addr_next[15:8];
        shr_oe_next[15:8] = BYTE_ONES;
      end
    end
    rd_n_next = !((state_next == ST_STROBE) && !wr_next);
    wr_n_next = !((state_next == ST_STROBE) && wr_next && (!lbmode_next || !wide_next || low_next));
    ale_next = (state_next == ST_ADDR);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seg_out_reg <= '0;
      seg_oe_reg <= '0;
      shr_out_reg <= '0;
      shr_oe_reg <= '0;
      la_out_reg <= '0;
      la_oe_reg <= '0;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      ale_reg <= 1'b0;
    end else begin
      seg_out_reg <= seg_out_next;
      seg_oe_reg <= seg_oe_next;
      shr_out_reg <= shr_out_next;
      shr_oe_reg <= shr_oe_next;
      la_out_reg <= la_out_next;
      la_oe_reg <= la_oe_next;
      rd_n_reg <= rd_n_next;
      wr_n_reg <= wr_n_next;
      ale_reg <= ale_next;
    end
  end

  assign o_acc_done = done_reg;
  assign o_acc_rdata = rdata_reg;
  assign o_segment_port_out = seg_out_reg;
  assign o_segment_port_oe = seg_oe_reg;
  assign o_segment_port_sync = seg_sync_reg;
  assign o_shared_addr_data_port_out = shr_out_reg;
  assign o_shared_addr_data_port_oe = shr_oe_reg;
  assign o_shared_port_sync = shr_sync_reg;
  assign o_low_address_port_out = la_out_reg;
  assign o_low_address_port_oe = la_oe_reg;
  assign o_read_strobe_n = rd_n_reg;
  assign o_low_byte_write_strobe_n = wr_n_reg;
  assign o_addr_latch = ale_reg;
  assign o_boot_external = boot_ext_reg;
  assign o_boot_valid = boot_valid_reg;

  chk_seg_input_hiz: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!i_ext_bus_en && state_reg == ST_IDLE) |=> (o_segment_port_oe == $past(i_seg_gpio_dir)))
    else $error("segment port enable does not follow direction");
  chk_seg_addr_lines: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_reg == ST_STROBE && bus_en_reg && seg_sel_reg == SEG_EIGHT)
      |-> (o_segment_port_out == addr_reg[23:16] && o_segment_port_oe == BYTE_ONES))
    else $error("segment port not carrying upper address");
  chk_read_strobe_on: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_reg == ST_ADDR && !wr_reg) |=> (!o_read_strobe_n && o_low_byte_write_strobe_n))
    else $error("read strobe missing on read access");
  chk_write_plain: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_reg == ST_ADDR && wr_reg && !lbmode_reg) |=> (!o_low_byte_write_strobe_n && o_read_strobe_n))
    else $error("write strobe missing in plain mode");
  chk_write_low_mode: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_reg == ST_ADDR && wr_reg && lbmode_reg) |=> (o_low_byte_write_strobe_n == $past(wide_reg && !low_reg)))
    else $error("low byte write strobe wrong");
  chk_ready_extends: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_reg == ST_STROBE && wait_cnt_reg == '0 && rdy_en_reg && ready_sync_reg)
      |=> (state_reg == ST_STROBE && !(o_read_strobe_n && o_low_byte_write_strobe_n && !lbmode_reg)))
    else $error("ready high did not extend access");
  chk_ale_single: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    take |=> o_addr_latch ##1 (!o_addr_latch && state_reg == ST_STROBE))
    else $error("address latch pulse malformed");
  chk_boot_capture: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_boot_valid) |-> (o_boot_external == !$past(strap_sync_reg)))
    else $error("fetch strap captured wrongly");
  chk_demux_data_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_reg == ST_STROBE && bus_en_reg && !mux_reg && wr_reg)
      |-> (o_shared_addr_data_port_out[7:0] == wdata_reg[7:0] && o_shared_addr_data_port_oe[7:0] == BYTE_ONES))
    else $error("demultiplexed write data not driven");
  chk_mux_addr_phase: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_reg == ST_ADDR && mux_reg) |-> (o_shared_addr_data_port_out[7:0] == addr_reg[7:0]))
    else $error("multiplexed address phase wrong");
  chk_demux_low_addr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_reg == ST_STROBE && bus_en_reg && !mux_reg)
      |-> (o_low_address_port_out == addr_reg[15:0] && o_low_address_port_oe == WORD_ONES))
    else $error("low address port not driving address");
  chk_strobes_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_reg == ST_IDLE || state_reg == ST_HOLD) |-> (o_read_strobe_n && o_low_byte_write_strobe_n))
    else $error("strobe active outside access");
endmodule
`default_nettype wire

/* verif/ext_mem_model.sv */
// Behavioural external memory with address latch, facing the bus pins
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  input wire logic i_clk,
  input wire logic i_mux,
  input wire logic i_ale,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [7:0] i_seg,
  input wire logic [15:0] i_ad,
  input wire logic [15:0] i_low_addr,
  input wire logic [3:0] i_ready_waits,
  output logic [15:0] o_data,
  output logic o_ready,
  output logic [23:0] o_lat_addr
);
  logic [15:0] mem [16] = '{default: 16'h0000};
  logic [15:0] last = 16'h0000;
  logic [3:0] cnt = 4'h0;
  logic strb_q = 1'b0;
  // Released lines show the inverse, so a late sample never sees stale data
  assign o_data = i_rd_n ? ~last : mem[o_lat_addr[3:0]];
  // Ready held high for a set count once a strobe starts
  assign o_ready = (cnt != 4'h0);
  always @(posedge i_clk) begin
    if (i_ale) o_lat_addr <= {i_seg, i_mux ? i_ad : i_low_addr};
    if (!i_wr_n) mem[o_lat_addr[3:0]] <= i_ad;
    if (!i_rd_n) last <= mem[o_lat_addr[3:0]];
    strb_q <= !(i_rd_n && i_wr_n);
    if (!(i_rd_n && i_wr_n) && !strb_q) cnt <= i_ready_waits;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  end
endmodule
`default_nettype wire

/* verif/external_memory_bus_pins_tb.sv */
// Self-checking bench for the external memory bus pin block
`timescale 1ns/1ps
`default_nettype none
module external_memory_bus_pins_tb;
  import ext_bus_pkg::*;
  logic clk, rst_n, bus_en, mux, b16, wmode, rdy_en, req, wr, lb, strap_n;
  logic done, rd_n, wr_n, ale, rdy, boot_ext, boot_ok;
  logic [1:0] ss;
  logic [3:0] rw;
  logic [7:0] sdir, sout, soe, seg_out, seg_sync;
  logic [15:0] wd, rdata, mdata, ad_pin, ad_out, ad_oe, la_out, la_oe, wr_oe, sh_dir, sh_sync;
  logic [23:0] addr, lat;
  int err_count, compares, rd_len, wr_len;
  assign ad_pin = (ad_oe & ad_out) | (~ad_oe & mdata);
  external_memory_bus_pins i_external_memory_bus_pins (
    .i_clk(clk), .i_rst_n(rst_n), .i_ext_bus_en(bus_en), .i_bus_mux(mux), .i_bus_16bit(b16),
    .i_write_strobe_mode_select(wmode), .i_ready_en(rdy_en), .i_wait_states(4'h3), .i_seg_sel(ss),
    .i_acc_req(req), .i_acc_write(wr), .i_acc_low_byte(lb), .i_acc_addr(addr), .i_acc_wdata(wd),
    .o_acc_done(done), .o_acc_rdata(rdata), .i_seg_gpio_dir(sdir), .i_seg_gpio_out(sout),
    .i_shared_gpio_dir(sh_dir), .i_shared_gpio_out(16'h5a5a), .i_low_addr_gpio_dir(16'h0000),
    .i_low_addr_gpio_out(16'h0000), .i_segment_port_in((seg_out & soe) | (~soe & 8'hc3)),
    .o_segment_port_out(seg_out), .o_segment_port_oe(soe), .o_segment_port_sync(seg_sync),
    .i_shared_addr_data_port_in(ad_pin), .o_shared_addr_data_port_out(ad_out),
    .o_shared_addr_data_port_oe(ad_oe), .o_shared_port_sync(sh_sync), .o_low_address_port_out(la_out),
    .o_low_address_port_oe(la_oe), .o_read_strobe_n(rd_n), .o_low_byte_write_strobe_n(wr_n),
    .o_addr_latch(ale), .i_ready(rdy), .i_external_fetch_strap_n(strap_n), .o_boot_external(boot_ext),
    .o_boot_valid(boot_ok));
  ext_mem_model i_ext_mem_model (.i_clk(clk), .i_mux(mux), .i_ale(ale), .i_rd_n(rd_n), .i_wr_n(wr_n),
    .i_seg(seg_out), .i_ad(ad_pin), .i_low_addr(la_out), .i_ready_waits(rw), .o_data(mdata),
    .o_ready(rdy), .o_lat_addr(lat));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Strobe lengths per access, cleared by the latch strobe
  always @(posedge clk) begin
    if (ale) begin
      rd_len <= 0;
      wr_len <= 0;
    end else begin
      rd_len <= rd_len + int'(!rd_n);
      wr_len <= wr_len + int'(!wr_n);
    end
    if (!wr_n) wr_oe <= ad_oe;
  end
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic do_reset(input logic s);
    @(posedge clk);
    rst_n <= 1'b0;
    strap_n <= s;
    repeat (2) @(negedge clk);
    chk("idle strobes", {rd_n, wr_n, ale}, 3'b110);
    @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic cfg(input logic m, b, w, r, input logic [1:0] s);
    @(posedge clk);
    mux <= m;
    b16 <= b;
    wmode <= w;
    rdy_en <= r;
    ss <= s;
  endtask
  // Request held until the latch strobe shows it was taken
  task automatic acc(input logic w, l, input logic [23:0] a, input logic [15:0] d);
    int n;
    @(posedge clk);
    req <= 1'b1;
    wr <= w;
    lb <= l;
    addr <= a;
    wd <= d;
    for (n = 0; n < 60; n++) begin
      @(negedge clk);
      if (done) break;
      if (ale) begin
        @(posedge clk);
        req <= 1'b0;
      end
    end
    if (n == 60) begin
      chk("access timeout", 1'b1, 1'b0);
      tally_and_finish();
    end
  endtask
  task automatic t_boot();
    for (int s = 1; s >= 0; s--) begin
      do_reset(s[0]);
      for (int n = 0; n < 8 && !boot_ok; n++) @(negedge clk);
      chk("boot valid", boot_ok, 1'b1);
      chk("boot source", boot_ext, !s[0]);
    end
  endtask
  task automatic t_demux();
    cfg(1'b0, 1'b1, 1'b0, 1'b0, 2'h3);
    acc(1'b1, 1'b0, 24'h5a1234, 16'hbeef);
    chk("demux address", lat, 24'h5a1234);
    chk("write strobe", wr_len, 4);
    chk("write data oe", wr_oe, 16'hffff);
    chk("low addr oe", la_oe, 16'hffff);
    acc(1'b0, 1'b0, 24'h5a1234, 16'h0000);
    chk("read data", rdata, 16'hbeef);
    chk("read strobe", rd_len, 4);
    chk("no write on read", wr_len, 0);
  endtask
  task automatic t_mux();
    cfg(1'b1, 1'b1, 1'b0, 1'b0, 2'h3);
    acc(1'b1, 1'b1, 24'hc3a5e6, 16'h1357);
    chk("mux address", lat, 24'hc3a5e6);
    acc(1'b0, 1'b0, 24'hc3a5e6, 16'h0000);
    chk("mux read", rdata, 16'h1357);
    cfg(1'b1, 1'b0, 1'b0, 1'b0, 2'h3);
    acc(1'b0, 1'b0, 24'h817ea6, 16'h0000);
    chk("mux8 address", lat, 24'h817ea6);
    chk("mux8 read", rdata, 16'h0057);
  endtask
  task automatic t_low_byte();
    for (int i = 0; i < 3; i++) begin
      cfg(1'b0, i < 2, 1'b1, 1'b0, 2'h3);
      acc(1'b1, i[0], 24'h000108, 16'h2468);
      chk("low byte strobe", wr_len, i == 0 ? 0 : 4);
    end
    chk("8-bit high byte oe", wr_oe, {sh_dir[15:8], 8'hff});
  endtask
  task automatic t_ready();
    cfg(1'b0, 1'b1, 1'b0, 1'b1, 2'h3);
    rw <= 4'h8;
    acc(1'b0, 1'b0, 24'h000004, 16'h0000);
    chk("ready stretch", rd_len >= 9 && rd_len <= 16, 1'b1);
    cfg(1'b0, 1'b1, 1'b0, 1'b0, 2'h3);
    acc(1'b0, 1'b0, 24'h000004, 16'h0000);
    chk("ready ignored", rd_len, 4);
    @(posedge clk);
    rw <= 4'h0;
  endtask
  // Two, four and no segment lines selected, then bus off; unselected lines stay general I/O
  task automatic t_segment();
    cfg(1'b0, 1'b1, 1'b0, 1'b0, 2'h1);
    acc(1'b0, 1'b0, 24'hff0004, 16'h0000);
    chk("segment lines", lat[17:16], 2'h3);
    chk("segment oe", soe, 8'hf3);
    chk("segment gpio out", seg_out[7:2], 6'h28);
    cfg(1'b0, 1'b1, 1'b0, 1'b0, 2'h2);
    acc(1'b0, 1'b0, 24'h5b0004, 16'h0000);
    chk("segment four", {soe, seg_out}, 16'hffab);
    chk("segment four lines", lat[19:16], 4'hb);
    cfg(1'b0, 1'b1, 1'b0, 1'b0, 2'h0);
    acc(1'b0, 1'b0, 24'h5b0004, 16'h0000);
    chk("segment none", {soe, seg_out}, 16'hf0a0);
    @(posedge clk);
    bus_en <= 1'b0;
    sdir <= 8'h0f;
    repeat (4) @(negedge clk);
    chk("gpio oe", soe, 8'h0f);
    chk("shared gpio oe", ad_oe, sh_dir);
    chk("input pin level", seg_sync[7:4], 4'hc);
    chk("low addr gpio oe", la_oe, 16'h0000);
    chk("shared pin level", sh_sync & sh_dir, 16'h5a5a & sh_dir);
  endtask
  initial begin
    err_count = 0;
    compares = 0;
    rst_n = 1'b0;
    strap_n = 1'b1;
    bus_en = 1'b1;
    {mux, b16, wmode, rdy_en, req, wr, lb} = 7'h00;
    ss = 2'h3;
    rw = 4'h0;
    sdir = 8'hf0;
    sout = 8'ha0;
    sh_dir = 16'h3c00;
    wd = 16'h0000;
    addr = 24'h000000;
    t_boot();
    t_demux();
    t_mux();
    t_low_byte();
    t_ready();
    t_segment();
    tally_and_finish();
  end
endmodule
`default_nettype wire
